/* File: logic/rlcrd_defs.svh */
`ifndef RLCRD_DEFS_SVH
`define RLCRD_DEFS_SVH

// channel indices into the reset synchroniser bank
`define RLCRD_CH_CPU      0
`define RLCRD_CH_MII_TX   1
`define RLCRD_CH_MII_RX   2
`define RLCRD_CH_GMII_TX  3
`define RLCRD_CH_GMII_RX  4
`define RLCRD_CH_TX_PATH  5
`define RLCRD_CH_RX_PATH  6
`define RLCRD_CH_RECONFIG 7
`define RLCRD_NUM_CH      8

// reset value of every synchroniser stage: reset asserted
`define RLCRD_SYNC_RESET  1'b0

// cycles from a reset input edge to the matching output edge
`define RLCRD_SYNC_CYCLES 2

`endif

/* File: logic/rlcrd_pkg.sv */
package rlcrd_pkg;

  typedef enum logic [1:0] {
    PS_RESET = 2'b00,
    PS_WAIT  = 2'b01,
    PS_RUN   = 2'b10
  } rlcrd_path_state_t;

  // active-low per-domain resets, as they leave the block
  typedef struct packed {
    logic regs_n;
    logic mii_tx_n;
    logic mii_rx_n;
    logic gmii_tx_n;
    logic gmii_rx_n;
    logic tx_path_n;
    logic rx_path_n;
  } rlcrd_domain_resets_t;

endpackage

/* File: logic/rlcrd_reset_domains.sv */
`timescale 1ns/1ps
`include "rlcrd_defs.svh"

module rlcrd_reset_domains #(
  parameter bit NEWER_DEVICE   = 1'b1,
  parameter bit STARTUP_SM_EN  = 1'b0,
  parameter bit REG_ACCESS_EN  = 1'b0,
  parameter bit AUTONEG_EN     = 1'b0,
  parameter bit DELAY_CAL_EN   = 1'b0
) (
  input  wire logic                          clk_in,
  input  wire logic                          reset_n_in,
  input  wire logic                          global_reset_n_in,
  input  wire logic                          tx_path_reset_n_in,
  input  wire logic                          rx_path_reset_n_in,
  input  wire logic                          cpu_reset_n_in,
  input  wire logic                          mii_tx_reset_n_in,
  input  wire logic                          mii_rx_reset_n_in,
  input  wire logic                          gmii_tx_reset_n_in,
  input  wire logic                          gmii_rx_reset_n_in,
  input  wire logic                          reconfig_reset_in,
  input  wire logic                          tx_xcvr_ready_in,
  input  wire logic                          rx_xcvr_ready_in,
  output rlcrd_pkg::rlcrd_domain_resets_t    domain_resets_n_out,
  output logic                               reconfig_reset_out,
  output logic                               tx_enable_out,
  output logic                               rx_enable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reconfiguration reset presence

  localparam bit HAS_RECONFIG = NEWER_DEVICE ?
    (STARTUP_SM_EN | REG_ACCESS_EN | AUTONEG_EN | DELAY_CAL_EN) :
    (AUTONEG_EN | STARTUP_SM_EN);

  ////////////////////////////////////////////////////////////////////////////
  // reset synchroniser bank

  logic [`RLCRD_NUM_CH-1:0] raw_n;
  logic [`RLCRD_NUM_CH-1:0] meta_r;
  logic [`RLCRD_NUM_CH-1:0] meta_nxt;
  logic [`RLCRD_NUM_CH-1:0] sync_nxt;

  always_comb begin
    raw_n[`RLCRD_CH_CPU]      = cpu_reset_n_in;
    raw_n[`RLCRD_CH_MII_TX]   = mii_tx_reset_n_in;
    raw_n[`RLCRD_CH_MII_RX]   = mii_rx_reset_n_in;
    raw_n[`RLCRD_CH_GMII_TX]  = gmii_tx_reset_n_in;
    raw_n[`RLCRD_CH_GMII_RX]  = gmii_rx_reset_n_in;
    // path scope: own path reset or global
    raw_n[`RLCRD_CH_TX_PATH]  = tx_path_reset_n_in & global_reset_n_in;
    raw_n[`RLCRD_CH_RX_PATH]  = rx_path_reset_n_in & global_reset_n_in;
    raw_n[`RLCRD_CH_RECONFIG] = ~(reconfig_reset_in & HAS_RECONFIG);
  end

  // first stage here; resets_r and reconfig_reset_out form the second
  // path state machines read the same next value so enables drop with
  // the path reset; safe only because every input is synchronous
  genvar gi;
  generate
    for (gi = 0; gi < `RLCRD_NUM_CH; gi++) begin : g_sync
      always_comb begin
        meta_nxt[gi] = reset_n_in ? raw_n[gi] : `RLCRD_SYNC_RESET;
        sync_nxt[gi] = reset_n_in ? meta_r[gi] : `RLCRD_SYNC_RESET;
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    meta_r <= meta_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // domain reset outputs

  rlcrd_pkg::rlcrd_domain_resets_t resets_nxt;
  rlcrd_pkg::rlcrd_domain_resets_t resets_r;

  always_comb begin
    // cpu reset owns the register bank
    // global reset kept off the register bank
    resets_nxt.regs_n    = sync_nxt[`RLCRD_CH_CPU];
    resets_nxt.mii_tx_n  = sync_nxt[`RLCRD_CH_MII_TX];
    resets_nxt.mii_rx_n  = sync_nxt[`RLCRD_CH_MII_RX];
    resets_nxt.gmii_tx_n = sync_nxt[`RLCRD_CH_GMII_TX];
    resets_nxt.gmii_rx_n = sync_nxt[`RLCRD_CH_GMII_RX];
    resets_nxt.tx_path_n = sync_nxt[`RLCRD_CH_TX_PATH];
    resets_nxt.rx_path_n = sync_nxt[`RLCRD_CH_RX_PATH];
  end

  // second stage registered here, so outputs leave straight from a flop
  always_ff @(posedge clk_in) begin
    resets_r           <= resets_nxt;
    // absent reconfig reset stays low, block reset included
    reconfig_reset_out <= HAS_RECONFIG & ~sync_nxt[`RLCRD_CH_RECONFIG];
  end

  assign domain_resets_n_out = resets_r;

  ////////////////////////////////////////////////////////////////////////////
  // data path gating on transceiver ready

  rlcrd_pkg::rlcrd_path_state_t tx_state_r;
  rlcrd_pkg::rlcrd_path_state_t tx_state_nxt;
  rlcrd_pkg::rlcrd_path_state_t rx_state_r;
  rlcrd_pkg::rlcrd_path_state_t rx_state_nxt;

  function automatic rlcrd_pkg::rlcrd_path_state_t path_next(
    input rlcrd_pkg::rlcrd_path_state_t cur,
    input logic                         path_rst_n,
    input logic                         ready
  );
    rlcrd_pkg::rlcrd_path_state_t nxt;
    nxt = cur;
    if (!path_rst_n) begin
      nxt = rlcrd_pkg::PS_RESET;
    end else begin
      case (cur)
        rlcrd_pkg::PS_RESET: nxt = rlcrd_pkg::PS_WAIT;
        rlcrd_pkg::PS_WAIT: nxt = ready ? rlcrd_pkg::PS_RUN : cur;
        // ready dropped by a triggered controller
        rlcrd_pkg::PS_RUN: nxt = ready ? cur : rlcrd_pkg::PS_WAIT;
        default: nxt = rlcrd_pkg::PS_RESET;
      endcase
    end
    return nxt;
  endfunction

  always_comb begin
    tx_state_nxt = path_next(tx_state_r, resets_nxt.tx_path_n,
                             tx_xcvr_ready_in);
    rx_state_nxt = path_next(rx_state_r, resets_nxt.rx_path_n,
                             rx_xcvr_ready_in);
  end

  always_ff @(posedge clk_in) begin
    tx_state_r    <= tx_state_nxt;
    rx_state_r    <= rx_state_nxt;
    tx_enable_out <= (tx_state_nxt == rlcrd_pkg::PS_RUN);
    rx_enable_out <= (rx_state_nxt == rlcrd_pkg::PS_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  cpu_reset_reach_a: assert property (
    !cpu_reset_n_in |=> ##1 !domain_resets_n_out.regs_n)
    else $error("cpu reset did not reach register bank");

  global_spares_regs_a: assert property (
    $past(cpu_reset_n_in, 2) && $past(cpu_reset_n_in) &&
    $past(reset_n_in, 2) && $past(reset_n_in) && !$past(global_reset_n_in, 2)
    |-> domain_resets_n_out.regs_n)
    else $error("global reset cleared register bank");

  mii_tx_reset_a: assert property (
    !mii_tx_reset_n_in |-> ##2 !domain_resets_n_out.mii_tx_n)
    else $error("10/100 tx reset not applied");

  mii_rx_reset_a: assert property (
    !mii_rx_reset_n_in |-> ##2 !domain_resets_n_out.mii_rx_n)
    else $error("10/100 rx reset not applied");

  gmii_tx_reset_a: assert property (
    !gmii_tx_reset_n_in |-> ##2 !domain_resets_n_out.gmii_tx_n)
    else $error("gigabit tx reset not applied");

  gmii_rx_reset_a: assert property (
    !gmii_rx_reset_n_in |-> ##2 !domain_resets_n_out.gmii_rx_n)
    else $error("gigabit rx reset not applied");

  tx_release_sync_a: assert property (
    $rose(domain_resets_n_out.tx_path_n) |->
    $past(tx_path_reset_n_in & global_reset_n_in, 2) &&
    $past(reset_n_in, 2) &&
    !($past(tx_path_reset_n_in & global_reset_n_in, 3) &&
      $past(reset_n_in, 3)))
    else $error("tx path reset released without two stages");

  rx_release_sync_a: assert property (
    $rose(domain_resets_n_out.rx_path_n) |->
    $past(rx_path_reset_n_in & global_reset_n_in, 2) &&
    $past(reset_n_in, 2) &&
    !($past(rx_path_reset_n_in & global_reset_n_in, 3) &&
      $past(reset_n_in, 3)))
    else $error("rx path reset released without two stages");

  tx_idle_until_ready_a: assert property (
    tx_enable_out |-> $past(tx_xcvr_ready_in) && domain_resets_n_out.tx_path_n)
    else $error("tx path enabled without ready");

  rx_idle_until_ready_a: assert property (
    !rx_xcvr_ready_in |=> !rx_enable_out)
    else $error("rx path enabled without ready");

  reconfig_absent_a: assert property (
    !HAS_RECONFIG |-> !reconfig_reset_out)
    else $error("reconfig reset present while disabled");

endmodule

/* File: testbench/rlcrd_xcvr_ctl_model.sv */
`timescale 1ns/1ps
module rlcrd_xcvr_ctl_model (
  input  wire logic       clk_in,
  input  wire logic       trig_n_in,
  input  wire logic [3:0] delay_in,
  output logic            ready_out
);
  logic [3:0] cnt_r;
  //////////////////////////////////////////////////////////////////////
  // own trigger only
  always_ff @(posedge clk_in) begin
    if (!trig_n_in) begin
      cnt_r     <= 4'h0;
      ready_out <= 1'b0;
    end else if (cnt_r != delay_in) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      ready_out <= 1'b1;
    end
  end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic                            clk_in, reset_n_in, global_n, tx_n, rx_n;
  logic                            rc_in, rc_out, tx_rdy, rx_rdy;
  logic                            tx_kick_n, rx_kick_n, tx_en, rx_en;
  logic [4:0]                      side_n;
  logic [3:0]                      dly;
  rlcrd_pkg::rlcrd_domain_resets_t dom_n;
  int                              mismatches, n_tests;
  //////////////////////////////////////////////////////////////////////
  rlcrd_reset_domains i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .global_reset_n_in(global_n), .tx_path_reset_n_in(tx_n),
    .rx_path_reset_n_in(rx_n), .cpu_reset_n_in(side_n[4]),
    .mii_tx_reset_n_in(side_n[3]), .mii_rx_reset_n_in(side_n[2]),
    .gmii_tx_reset_n_in(side_n[1]), .gmii_rx_reset_n_in(side_n[0]),
    .reconfig_reset_in(rc_in), .tx_xcvr_ready_in(tx_rdy),
    .rx_xcvr_ready_in(rx_rdy), .domain_resets_n_out(dom_n),
    .reconfig_reset_out(rc_out), .tx_enable_out(tx_en),
    .rx_enable_out(rx_en));
  // shared reset source: path and global resets also trigger the models
  rlcrd_xcvr_ctl_model i_tx_ctl (.clk_in(clk_in), .delay_in(dly),
    .trig_n_in(reset_n_in & global_n & tx_n & tx_kick_n),
    .ready_out(tx_rdy));
  rlcrd_xcvr_ctl_model i_rx_ctl (.clk_in(clk_in), .delay_in(dly),
    .trig_n_in(reset_n_in & global_n & rx_n & rx_kick_n),
    .ready_out(rx_rdy));
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task step(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task chk(input logic [6:0] got, input logic [6:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // bounded wait: both paths running again
  task wait_en;
    for (int i = 0; i < 30 && !(tx_en === 1'b1 && rx_en === 1'b1); i++)
      step(1);
    chk({tx_en, rx_en}, 7'h03, "enables not back");
  endtask
  task t_side;
    for (int i = 0; i < 5; i++) begin
      side_n = ~(5'h01 << i);
      step(1);
      chk(dom_n, 7'h7f, "side reset too early");
      step(2);
      chk(dom_n, {~(5'h01 << i), 2'b11}, "side reset scope");
      chk({tx_en, rx_en}, 7'h03, "side reset hit path");
      side_n = 5'h1f;
      step(3);
      chk(dom_n, 7'h7f, "side release");
    end
  endtask
  task t_global;
    dly = 4'h8;
    global_n = 1'b0;
    rc_in = 1'b1;
    step(3);
    chk(dom_n, 7'h7c, "global scope");
    chk({tx_en, rx_en, rc_out}, 7'h00, "global outputs");
    global_n = 1'b1;
    rc_in = 1'b0;
    step(5);
    chk(dom_n, 7'h7f, "global release");
    chk({tx_en, rx_en}, 7'h00, "ran before ready");
    wait_en;
  endtask
  task t_path;
    for (int i = 0; i < 2; i++) begin
      {tx_n, rx_n} = ~(2'b10 >> i);
      step(3);
      chk(dom_n, {5'h1f, ~(2'b10 >> i)}, "path scope");
      chk({tx_en, rx_en}, {5'h00, ~(2'b10 >> i)}, "path enables");
      {tx_n, rx_n} = 2'b11;
      wait_en;
    end
  endtask
  task t_ready;
    dly = 4'h2;
    for (int i = 0; i < 2; i++) begin
      {tx_kick_n, rx_kick_n} = ~(2'b10 >> i);
      step(3);
      chk({tx_en, rx_en}, {5'h00, ~(2'b10 >> i)},
          "ready low ignored");
      chk(dom_n, 7'h7f, "ready touched resets");
      {tx_kick_n, rx_kick_n} = 2'b11;
      wait_en;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    mismatches++;
    stop_test;
  end
  initial begin
    {global_n, tx_n, rx_n, tx_kick_n, rx_kick_n, rc_in} = 6'h3e;
    side_n = 5'h1f;
    dly = 4'h2;
    reset_n_in = 1'b0;
    step(12);
    reset_n_in = 1'b1;
    wait_en;
    t_side;
    t_global;
    t_path;
    t_ready;
    stop_test;
  end
endmodule
